// File: verilog/charger_setpoint_map.vh
// Register map, field positions, reset values and decode limits of the
// charger setpoint decoder.
// Assumes it is included by its bare name from the design files.
//
// What this block does
// - Charge-voltage word is millivolts; drop 4 LSBs, next 11 bits form voltage code.
// - Charge-voltage requests above 19.200 V saturate to exactly 19.200 V.
// - Charge-voltage requests below 1.024 V give zero setpoint and stop charging.
// - Charge-current word is milliamps; drop 7 LSBs, next 6 bits form current code.
// - Charge-current requests above 8.064 A are limited to 8.064 A.
// - Nonzero charge-current requests from 1 mA to 128 mA become 128 mA.
// - After power-on reset the charge current stands at 128 mA until rewritten.
// - Effective voltage is the smaller of setpoint and the voltage ceiling input.
// - Effective current is the smaller of setpoint and the current ceiling input.
// - Current loop governs below the voltage setpoint, voltage loop once it is reached.
// - Source loop takes control when load plus charger input exceeds the limit.
// - Source and load switch drives follow adapter presence, power fail and the conditioning cycle.
// - On host command a conditioning cycle discharges the battery, then recharges.
// - Adapter present whenever input supply sense exceeds 7.5 V.
// - Power fail whenever input supply is below battery plus 0.3 V.
// - Battery present whenever thermistor is below 0.91 of logic supply.
// - Battery undervoltage whenever battery is below 2.5 V.
// - Logic-supply undervoltage whenever logic supply is below 2.5 V.
// - State word bits 15, 14, 13 show adapter, battery present, power fail.
// - Battery undervoltage cuts current to 128 mA, setpoint kept; resume above 2.7 V.
// - Logic undervoltage ignores bus writes, stops charging, returns to reset state.
`ifndef CHARGER_SETPOINT_MAP_VH
`define CHARGER_SETPOINT_MAP_VH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define OFS_VOLT_SET    12'h000
`define OFS_CURR_SET    12'h004
`define OFS_STATE_WORD  12'h008
`define OFS_CONTROL     12'h00c
`define OFS_ID          12'h010

// ------------------------------------------------------------------
// Reset values and identity
// ------------------------------------------------------------------
`define RST_VOLT_SET    16'h0000
`define RST_CURR_SET    16'h0080
`define ID_VALUE        16'h5a01

// ------------------------------------------------------------------
// Decode limits in millivolts, milliamps and DAC codes
// ------------------------------------------------------------------
`define VOLT_MAX_MV     16'h4b00
`define VOLT_MIN_MV     16'h0400
`define VOLT_MAX_CODE   11'h4b0
`define VOLT_LSB_POS    4
`define VOLT_MSB_POS    14
`define CURR_MAX_MA     16'h1f80
`define CURR_LSB_POS    7
`define CURR_MSB_POS    12
`define CURR_MAX_CODE   6'h3f
`define CURR_FLOOR_CODE 6'h01

// ------------------------------------------------------------------
// State word and control field positions
// ------------------------------------------------------------------
`define ST_ADAPTER      15
`define ST_BATTERY      14
`define ST_PWR_FAIL     13
`define ST_BATTERY_SENSE_UV      12
`define ST_LOGIC_UV     11
`define ST_COND_RUN     10
`define ST_COND_DONE    9
`define ST_CHARGING     3
`define ST_LOOP_SRC     2
`define ST_LOOP_VOLT    1
`define ST_LOOP_CURR    0
`define CTL_COND_START  0
`define CTL_DONE_CLR    1

`endif

// File: verilog/sync_bank.v
// Bank of two-flop synchronisers for slow level inputs.
// Assumes each input is a level from outside the pclk domain.
`timescale 1ns/1ps
module sync_bank #(
   parameter WIDTH = 6
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire [WIDTH-1:0] async_in,
   output wire [WIDTH-1:0] sync_out
);

   // ------------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_sync
         reg meta_q;
         reg stable_q;
         // First flop feeds only the second flop.
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q   <= 1'b0;
               stable_q <= 1'b0;
            end else begin
               meta_q   <= async_in[i];
               stable_q <= meta_q;
            end
         end
         assign sync_out[i] = stable_q;
      end
   endgenerate

endmodule // sync_bank

// File: verilog/setpoint_clamp.v
// Picks the smaller of a programmed code and a ceiling code.
// Assumes both codes share one scale and are from the pclk domain.
`timescale 1ns/1ps
module setpoint_clamp #(
   parameter WIDTH = 11
) (
   input  wire [WIDTH-1:0] setpoint,
   input  wire [WIDTH-1:0] ceiling,
   output wire [WIDTH-1:0] effective
);

   // ------------------------------------------------------------------
   // Minimum selection
   // ------------------------------------------------------------------
   // The ceiling only ever lowers the programmed value.
   assign effective = (ceiling < setpoint) ? ceiling : setpoint;

endmodule // setpoint_clamp

// File: verilog/charger_setpoint_decoder.v
// Charger setpoint decoder: APB registers, setpoint decode, ceiling
// clamps, loop arbitration, operating states and power-switch selection.
// Assumes comparator and ceiling inputs come from the analog side,
// asynchronous to pclk, and that the ceiling codes change slowly.
`timescale 1ns/1ps
`include "charger_setpoint_map.vh"
module charger_setpoint_decoder (
   input  wire        pclk,
   input  wire        presetn,
   // APB slave.
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Comparator levels from the analog side.
   input  wire        input_supply_above_adapter,
   input  wire        input_supply_below_battery,
   input  wire        thermistor_below_present,
   input  wire        battery_below_uv,
   input  wire        battery_above_resume,
   input  wire        logic_supply_below_uv,
   input  wire        battery_at_setpoint,
   input  wire        source_over_limit,
   // Ceiling codes from the limit inputs, already in DAC units.
   input  wire [10:0] voltage_ceiling_input,
   input  wire [5:0]  current_ceiling_input,
   // Converter and switch controls.
   output reg  [10:0] voltage_dac_code,
   output reg  [5:0]  current_dac_code,
   output reg         charge_enable,
   output reg         voltage_loop,
   output reg         charge_current_loop,
   output reg         source_current_loop,
   output reg         source_switch_drive,
   output reg         load_switch_drive,
   output reg         adapter_present_flag
);

   // ------------------------------------------------------------------
   // Address decode helper
   // ------------------------------------------------------------------
   // Matches a word-aligned offset against the bus address.
   function addr_hit;
      input [11:0] addr;
      input [11:0] ofs;
      begin
         addr_hit = (addr[11:2] == ofs[11:2]);
      end
   endfunction

   // ------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------
   wire [7:0]  cmp_sync;
   wire [16:0] ceil_sync;
   wire        adapter_s;
   wire        pwr_fail_s;
   wire        battery_sense_here_s;
   wire        battery_sense_low_s;
   wire        battery_sense_ok_s;
   wire        logic_uv_s;
   wire        at_setpoint_s;
   wire        over_limit_s;
   wire [10:0] volt_ceil_s;
   wire [5:0]  curr_ceil_s;
   wire [10:0] volt_eff;
   wire [5:0]  curr_eff;
   wire        setup_phase;
   wire        access_ok;
   wire        wr_ok;
   wire        mapped;

   reg  [15:0] volt_set_q;
   reg  [15:0] curr_set_q;
   reg         battery_sense_uv_q;
   reg         logic_uv_q;
   reg         cond_run_q;
   reg         cond_done_q;
   reg  [10:0] volt_code;
   reg  [5:0]  curr_code;
   reg  [5:0]  curr_comp;
   reg         volt_stop;
   reg         run_d;
   reg  [15:0] state_word;
   reg  [31:0] rdata_d;

   // ------------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------------
   // All comparator levels pass two flops before any decision.
   sync_bank #(
      .WIDTH    (8)
   ) u_cmp_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({source_over_limit, battery_at_setpoint, logic_supply_below_uv,
                  battery_above_resume, battery_below_uv, thermistor_below_present,
                  input_supply_below_battery, input_supply_above_adapter}),
      .sync_out (cmp_sync)
   );

   // The ceiling codes are quasi-static levels and take the same path.
   sync_bank #(
      .WIDTH    (17)
   ) u_ceil_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({current_ceiling_input, voltage_ceiling_input}),
      .sync_out (ceil_sync)
   );

   // Named views of the synchronised levels.
   assign adapter_s     = cmp_sync[0];
   assign pwr_fail_s    = cmp_sync[1];
   assign battery_sense_here_s   = cmp_sync[2];
   assign battery_sense_low_s    = cmp_sync[3];
   assign battery_sense_ok_s     = cmp_sync[4];
   assign logic_uv_s    = cmp_sync[5];
   assign at_setpoint_s = cmp_sync[6];
   assign over_limit_s  = cmp_sync[7];
   assign volt_ceil_s   = ceil_sync[10:0];
   assign curr_ceil_s   = ceil_sync[16:11];

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   // Setup phase arms pready; the access phase then completes at once.
   assign setup_phase = psel & ~penable & ~pready;
   assign access_ok   = psel & penable & pready;
   assign wr_ok       = access_ok & pwrite & ~logic_uv_q;
   assign mapped      = addr_hit(paddr, `OFS_VOLT_SET) | addr_hit(paddr, `OFS_CURR_SET) |
                        addr_hit(paddr, `OFS_STATE_WORD) | addr_hit(paddr, `OFS_CONTROL) |
                        addr_hit(paddr, `OFS_ID);

   // ------------------------------------------------------------------
   // Setpoint registers
   // ------------------------------------------------------------------
   // Setpoints return to power-on values while the logic supply is low,
   // so recovery starts from the reset state.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         volt_set_q <= `RST_VOLT_SET;
         curr_set_q <= `RST_CURR_SET;
      end else if (logic_uv_q) begin
         volt_set_q <= `RST_VOLT_SET;
         curr_set_q <= `RST_CURR_SET;
      end else if (wr_ok) begin
         if (addr_hit(paddr, `OFS_VOLT_SET)) begin
            volt_set_q <= pwdata[15:0];
         end
         if (addr_hit(paddr, `OFS_CURR_SET)) begin
            curr_set_q <= pwdata[15:0];
         end
      end
   end

   // ------------------------------------------------------------------
   // Operating states
   // ------------------------------------------------------------------
   // Battery undervoltage has hysteresis: set below the low threshold,
   // cleared only once the battery climbs above the resume threshold.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         battery_sense_uv_q  <= 1'b0;
         logic_uv_q <= 1'b0;
      end else begin
         logic_uv_q <= logic_uv_s;
         if (battery_sense_low_s) begin
            battery_sense_uv_q <= 1'b1;
         end else if (battery_sense_ok_s) begin
            battery_sense_uv_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Conditioning cycle
   // ------------------------------------------------------------------
   // A start command isolates the adapter; the discharge ends when the
   // battery reaches undervoltage, which marks full depth of discharge.
   // The done flag is set by hardware and cleared by a write of one;
   // a set in the same cycle as the clear wins.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cond_run_q  <= 1'b0;
         cond_done_q <= 1'b0;
      end else if (logic_uv_q) begin
         cond_run_q  <= 1'b0;
         cond_done_q <= 1'b0;
      end else begin
         if (cond_run_q && battery_sense_uv_q) begin
            cond_run_q <= 1'b0;
         end else if (wr_ok && addr_hit(paddr, `OFS_CONTROL) && pwdata[`CTL_COND_START]) begin
            cond_run_q <= 1'b1;
         end
         if (cond_run_q && battery_sense_uv_q) begin
            cond_done_q <= 1'b1;
         end else if (wr_ok && addr_hit(paddr, `OFS_CONTROL) && pwdata[`CTL_DONE_CLR]) begin
            cond_done_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Setpoint decode
   // ------------------------------------------------------------------
   // Voltage: millivolt word, saturating high, zero below the floor.
   always @* begin
      volt_stop = 1'b0;
      if (volt_set_q > `VOLT_MAX_MV) begin
         volt_code = `VOLT_MAX_CODE;
      end else if (volt_set_q < `VOLT_MIN_MV) begin
         volt_code = 11'h000;
         volt_stop = 1'b1;
      end else begin
         volt_code = volt_set_q[`VOLT_MSB_POS:`VOLT_LSB_POS];
      end
   end

   // Current: milliamp word, saturating high, small nonzero words floored,
   // zero kept as an explicit off request.
   always @* begin
      if (curr_set_q == 16'h0000) begin
         curr_code = 6'h00;
      end else if (curr_set_q > `CURR_MAX_MA) begin
         curr_code = `CURR_MAX_CODE;
      end else if (curr_set_q[`CURR_MSB_POS:`CURR_LSB_POS] == 6'h00) begin
         curr_code = `CURR_FLOOR_CODE;
      end else begin
         curr_code = curr_set_q[`CURR_MSB_POS:`CURR_LSB_POS];
      end
   end

   // Battery undervoltage cuts compliance without touching the setpoint.
   always @* begin
      if (battery_sense_uv_q && (curr_code > `CURR_FLOOR_CODE)) begin
         curr_comp = `CURR_FLOOR_CODE;
      end else begin
         curr_comp = curr_code;
      end
   end

   // ------------------------------------------------------------------
   // Ceiling clamps
   // ------------------------------------------------------------------
   setpoint_clamp #(
      .WIDTH     (11)
   ) u_volt_clamp (
      .setpoint  (volt_code),
      .ceiling   (volt_ceil_s),
      .effective (volt_eff)
   );

   setpoint_clamp #(
      .WIDTH     (6)
   ) u_curr_clamp (
      .setpoint  (curr_comp),
      .ceiling   (curr_ceil_s),
      .effective (curr_eff)
   );

   // ------------------------------------------------------------------
   // Charge permission
   // ------------------------------------------------------------------
   // Charging needs an adapter, headroom, a battery, a live logic supply,
   // nonzero setpoints and no conditioning discharge in progress.
   always @* begin
      run_d = adapter_s & ~pwr_fail_s & battery_sense_here_s & ~logic_uv_q & ~volt_stop &
              (volt_eff != 11'h000) & (curr_eff != 6'h00) & ~cond_run_q;
   end

   // ------------------------------------------------------------------
   // Converter outputs and loop arbitration
   // ------------------------------------------------------------------
   // Source loop has top priority, then the voltage loop once the
   // battery reaches its setpoint, otherwise the current loop.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         voltage_dac_code    <= 11'h000;
         current_dac_code    <= 6'h00;
         charge_enable       <= 1'b0;
         voltage_loop        <= 1'b0;
         charge_current_loop <= 1'b0;
         source_current_loop <= 1'b0;
      end else begin
         voltage_dac_code    <= run_d ? volt_eff : 11'h000;
         current_dac_code    <= run_d ? curr_eff : 6'h00;
         charge_enable       <= run_d;
         source_current_loop <= run_d & over_limit_s;
         voltage_loop        <= run_d & ~over_limit_s & at_setpoint_s;
         charge_current_loop <= run_d & ~over_limit_s & ~at_setpoint_s;
      end
   end

   // ------------------------------------------------------------------
   // Power-source selection
   // ------------------------------------------------------------------
   // The adapter feeds the system when present and above the battery;
   // otherwise, or while conditioning, the battery feeds the load.
   // The two drives are complementary so the sources never short.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         source_switch_drive  <= 1'b0;
         load_switch_drive    <= 1'b0;
         adapter_present_flag <= 1'b0;
      end else begin
         source_switch_drive  <= adapter_s & ~pwr_fail_s & ~cond_run_q;
         load_switch_drive    <= ~(adapter_s & ~pwr_fail_s & ~cond_run_q);
         adapter_present_flag <= adapter_s;
      end
   end

   // ------------------------------------------------------------------
   // State word
   // ------------------------------------------------------------------
   always @* begin
      state_word                = 16'h0000;
      state_word[`ST_ADAPTER]   = adapter_s;
      state_word[`ST_BATTERY]   = battery_sense_here_s;
      state_word[`ST_PWR_FAIL]  = pwr_fail_s;
      state_word[`ST_BATTERY_SENSE_UV]   = battery_sense_uv_q;
      state_word[`ST_LOGIC_UV]  = logic_uv_q;
      state_word[`ST_COND_RUN]  = cond_run_q;
      state_word[`ST_COND_DONE] = cond_done_q;
      state_word[`ST_CHARGING]  = charge_enable;
      state_word[`ST_LOOP_SRC]  = source_current_loop;
      state_word[`ST_LOOP_VOLT] = voltage_loop;
      state_word[`ST_LOOP_CURR] = charge_current_loop;
   end

   // ------------------------------------------------------------------
   // Read data mux
   // ------------------------------------------------------------------
   always @* begin
      rdata_d = 32'h0000_0000;
      if (addr_hit(paddr, `OFS_VOLT_SET)) begin
         rdata_d[15:0] = volt_set_q;
      end else if (addr_hit(paddr, `OFS_CURR_SET)) begin
         rdata_d[15:0] = curr_set_q;
      end else if (addr_hit(paddr, `OFS_STATE_WORD)) begin
         rdata_d[15:0] = state_word;
      end else if (addr_hit(paddr, `OFS_CONTROL)) begin
         rdata_d[`CTL_COND_START] = cond_run_q;
      end else if (addr_hit(paddr, `OFS_ID)) begin
         rdata_d[15:0] = `ID_VALUE; // Arbitrary identity value.
      end
   end

   // ------------------------------------------------------------------
   // APB response
   // ------------------------------------------------------------------
   // Every transfer completes with no wait state. Unmapped addresses and
   // writes during logic undervoltage answer with an error.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (setup_phase) begin
         pready  <= 1'b1;
         pslverr <= ~mapped | (pwrite & logic_uv_q);
         prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

endmodule // charger_setpoint_decoder

// File: tb/charger_checker_asserts.sv
// Port checker for the charger setpoint decoder.
// Assumes it is bound into the decoder and sees only its ports.
`timescale 1ns/1ps
module charger_checker (
   input wire        pclk, presetn, charge_enable, adapter_present_flag,
   input wire        input_supply_above_adapter, input_supply_below_battery,
   input wire        battery_below_uv, source_switch_drive, load_switch_drive,
   input wire        voltage_loop, charge_current_loop, source_current_loop,
   input wire [10:0] voltage_ceiling_input, voltage_dac_code,
   input wire [5:0]  current_ceiling_input, current_dac_code
);
   // Levels cross two flops and one output stage, so four stable cycles settle.
   // The battery undervoltage state adds one more stage, so it needs five.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   volt_ceil_a: assert property ($stable(voltage_ceiling_input)[*4] |->
      voltage_dac_code <= voltage_ceiling_input) else $error("voltage above ceiling");
   curr_ceil_a: assert property ($stable(current_ceiling_input)[*4] |->
      current_dac_code <= current_ceiling_input) else $error("current above ceiling");
   uv_cap_a: assert property (battery_below_uv[*5] |-> current_dac_code <= 6'h01)
      else $error("current not cut in undervoltage");
   pwr_fail_a: assert property (input_supply_below_battery[*4] |->
      !source_switch_drive && !charge_enable) else $error("source on in power fail");
   adapter_seen_a: assert property (input_supply_above_adapter[*4] |->
      adapter_present_flag) else $error("adapter flag missing");
   off_zero_a: assert property (!charge_enable |->
      voltage_dac_code == 11'h000 && current_dac_code == 6'h00) else $error("codes while off");
   loop_one_a: assert property ($onehot0({voltage_loop, charge_current_loop,
      source_current_loop}) && charge_enable == (voltage_loop || charge_current_loop ||
      source_current_loop)) else $error("loop selection wrong");
   switch_pair_a: assert property ($past(presetn) |->
      load_switch_drive != source_switch_drive) else $error("switch drives not paired");
   cover property (source_current_loop);
   cover property (voltage_loop);
   cover property (battery_below_uv && charge_enable);
endmodule // charger_checker

bind charger_setpoint_decoder charger_checker charger_checker_inst (.*);

// File: tb/analog_side_model.sv
// Analog side of the charger: comparator levels seen by the decoder.
// Assumes the bench sets wanted levels; lines move just after pclk rises.
`timescale 1ns/1ps
module analog_side_model (
   input  wire       pclk,
   input  wire [7:0] want,
   output reg  [7:0] cmp
);
   // Resume comparator cannot be high while the battery sits below 2.5 V.
   always @(posedge pclk) begin
      cmp <= {want[7:5], want[4] & ~want[3], want[3:0]};
   end
endmodule // analog_side_model

// File: tb/tb_charger_setpoint_decoder.sv
// Self-checking bench for the charger setpoint decoder over APB.
// Assumes the checker is bound in and the analog model drives comparators.
`timescale 1ns/1ps
module tb_charger_setpoint_decoder;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  want = 8'h15, cmp;
   logic [10:0] voltage_ceiling_input = 11'h7ff, voltage_dac_code;
   logic [5:0]  current_ceiling_input = 6'h3f, current_dac_code;
   logic        pready, pslverr, err, charge_enable, voltage_loop, charge_current_loop;
   logic        source_current_loop, source_switch_drive, load_switch_drive;
   logic        adapter_present_flag;
   int          error_cnt = 0, checks = 0, cyc = 0;
   analog_side_model analog_side_model_inst (.pclk(pclk), .want(want), .cmp(cmp));
   charger_setpoint_decoder charger_setpoint_decoder_inst (.*,
      .input_supply_above_adapter(cmp[0]), .input_supply_below_battery(cmp[1]),
      .thermistor_below_present(cmp[2]), .battery_below_uv(cmp[3]),
      .battery_above_resume(cmp[4]), .logic_supply_below_uv(cmp[5]),
      .battery_at_setpoint(cmp[6]), .source_over_limit(cmp[7]));
   always #5 pclk = ~pclk;
   // A hang counts as a mismatch and ends the run.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One APB transfer; the request holds until pready is seen at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wt();
      repeat (6) @(negedge pclk);
   endtask
   task lv(input logic [7:0] w);
      @(posedge pclk);
      want <= w;
      wt();
   endtask
   task t_decode();
      logic [15:0] vw [6] = '{16'h3000, 16'hffff, 16'h03ff, 16'h0400, 16'h4b01, 16'h3000};
      logic [15:0] cw [6] = '{16'h1234, 16'hffff, 16'h0001, 16'h0001, 16'h0000, 16'h007f};
      logic [10:0] ev [6] = '{11'h300, 11'h4b0, 11'h000, 11'h040, 11'h000, 11'h300};
      logic [5:0]  ei [6] = '{6'h24, 6'h3f, 6'h00, 6'h01, 6'h00, 6'h01};
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, 12'h000, {16'h0000, vw[i]});
         apb(1'b1, 12'h004, {16'h0000, cw[i]});
         wt();
         chk(voltage_dac_code, ev[i]);
         chk(current_dac_code, ei[i]);
         chk(charge_enable, ev[i] != 11'h000);
      end
   endtask
   task t_limits();
      apb(1'b1, 12'h004, 32'h1234);
      voltage_ceiling_input <= 11'h100;
      current_ceiling_input <= 6'h05;
      wt();
      chk({voltage_dac_code, current_dac_code}, {11'h100, 6'h05});
      lv(8'h55);
      chk({source_current_loop, voltage_loop, charge_current_loop}, 3'b010);
      lv(8'hd5);
      chk({source_current_loop, voltage_loop, charge_current_loop}, 3'b100);
      @(posedge pclk);
      voltage_ceiling_input <= 11'h7ff;
      current_ceiling_input <= 6'h3f;
      lv(8'h15);
      chk({source_current_loop, voltage_loop, charge_current_loop}, 3'b001);
   endtask
   task t_states();
      lv(8'h17);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[15:13], 3'b111);
      chk({source_switch_drive, load_switch_drive, charge_enable}, 3'b010);
      lv(8'h14);
      chk({adapter_present_flag, source_switch_drive}, 2'b00);
      lv(8'h0d);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h1234);
      chk(current_dac_code, 32'h01);
      lv(8'h05);
      chk(current_dac_code, 32'h01);
      lv(8'h15);
      chk(current_dac_code, 32'h24);
   endtask
   // Conditioning runs until the battery falls into undervoltage.
   task t_cond();
      apb(1'b1, 12'h00c, 32'h1);
      wt();
      chk({source_switch_drive, load_switch_drive, charge_enable}, 3'b010);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, 32'h1);
      lv(8'h1d);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[10:9], 2'b01);
      lv(8'h15);
      chk(source_switch_drive, 1'b1);
      apb(1'b1, 12'h00c, 32'h2);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd[10:9], 2'b00);
   endtask
   task t_logic_uv();
      lv(8'h35);
      apb(1'b1, 12'h004, 32'h0400);
      chk({err, charge_enable}, 2'b10);
      lv(8'h15);
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h80);
      apb(1'b0, 12'h100, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, 32'h80);
      t_decode();
      t_limits();
      t_states();
      t_cond();
      t_logic_uv();
      summarize();
   end
endmodule // tb_charger_setpoint_decoder
